// ---- logic/ddrc_init_ctrl.sv ----
// memory controller configuration registers and start-up sequencer
`timescale 1ns/1ps
`include "ddrc_params.svh"
module ddrc_init_ctrl #(
  parameter int unsigned PWRUP_CYC = `DDRC_PWRUP_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic                       irq,
  output ddrc_pkg::ddrc_mem_type     mem_type,
  output ddrc_pkg::ddrc_pwr_type     mem_pwr,
  output ddrc_pkg::ddrc_mrs_type     mem_mrs,
  output logic                       init_complete_flag
);
  import ddrc_pkg::*;

  localparam int unsigned RESET_CYC = `DDRC_RESET_CYC;
  localparam int unsigned FIRST_CYC = `DDRC_FIRST_CMD_CYC;
  localparam int unsigned MRS_CYC   = `DDRC_MRS_CYC;

  logic [31:0]    lp_mode_register;
  logic [31:0]    lp_extended_mode_register;
  logic [31:0]    controller_control;
  logic [31:0]    delay_loop_control;
  logic [31:0]    calibration_address;
  logic [1:0]     irq_status;
  logic [1:0]     irq_mask;
  logic           wr_pend;
  logic [11:0]    wr_addr;
  logic [31:0]    wait_cnt;
  logic           start_seen;
  ddrc_state_type state;
  ddrc_state_type next_state;
  logic [31:0]    next_wait;

  // address phase decode
  wire        addr_phase = hsel & hready & htrans[1];
  wire        wr_take    = addr_phase & hwrite;
  wire [11:0] rd_ofs     = haddr[11:0];
  wire        do_write   = wr_pend;
  wire        wr_mode    = do_write & (wr_addr == `DDRC_OFS_MODE);
  wire        wr_ext     = do_write & (wr_addr == `DDRC_OFS_EXTMODE);
  wire        wr_ctl     = do_write & (wr_addr == `DDRC_OFS_CTL);
  wire        wr_loop    = do_write & (wr_addr == `DDRC_OFS_LOOP);
  wire        wr_cal     = do_write & (wr_addr == `DDRC_OFS_CALADDR);
  wire        wr_istat   = do_write & (wr_addr == `DDRC_OFS_IRQ_STAT);
  wire        wr_imask   = do_write & (wr_addr == `DDRC_OFS_IRQ_MASK);
  // start is a one-shot; a write while the sequence runs is ignored
  wire        start_req  = wr_ctl & hwdata[`DDRC_CTL_INIT_BIT] & (state == DDRC_IDLE);
  wire        seq_done   = (state == DDRC_MRS_EM) & (wait_cnt == 32'h00000000);
  // events: done, and a start refused because the sequencer has left idle (running or done)
  wire        start_bad  = wr_ctl & hwdata[`DDRC_CTL_INIT_BIT] & (state != DDRC_IDLE);
  wire [1:0]  irq_set    = {start_bad, seq_done};
  wire [31:0] status_word = {29'h0000000, state == DDRC_IDLE, start_seen,
                             init_complete_flag};

  wire [31:0] rd_mux =
    (rd_ofs == `DDRC_OFS_MODE)     ? lp_mode_register :
    (rd_ofs == `DDRC_OFS_EXTMODE)  ? lp_extended_mode_register :
    (rd_ofs == `DDRC_OFS_CTL)      ? controller_control :
    (rd_ofs == `DDRC_OFS_LOOP)     ? delay_loop_control :
    (rd_ofs == `DDRC_OFS_CALADDR)  ? calibration_address :
    (rd_ofs == `DDRC_OFS_STATUS)   ? status_word :
    (rd_ofs == `DDRC_OFS_IRQ_STAT) ? {30'h00000000, irq_status} :
    (rd_ofs == `DDRC_OFS_IRQ_MASK) ? {30'h00000000, irq_mask} : 32'h00000000;

  // bus slave: zero wait states, always OKAY
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 12'h000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= wr_take;
      wr_addr <= haddr[11:0];
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // config registers; unused bits masked so they stay zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lp_mode_register          <= `DDRC_RST_MODE;
      lp_extended_mode_register <= `DDRC_RST_EXTMODE;
      controller_control        <= `DDRC_RST_CTL;
      delay_loop_control        <= `DDRC_RST_LOOP;
      calibration_address       <= `DDRC_RST_CALADDR;
      irq_mask                  <= 2'h0;
    end else begin
      if (wr_mode) lp_mode_register <= hwdata & `DDRC_MODE_USED_MSK;
      if (wr_ext) lp_extended_mode_register <= hwdata & `DDRC_EMR_USED_MSK;
      // start bit is masked off on write and never stored, so a readback shows no pending start
      if (wr_ctl) begin
        controller_control <= hwdata & `DDRC_CTL_USED_MSK & ~(32'h1 << `DDRC_CTL_INIT_BIT);
      end
      if (wr_loop) delay_loop_control <= hwdata & `DDRC_LOOP_USED_MSK;
      if (wr_cal) calibration_address <= hwdata;
      if (wr_imask) irq_mask <= hwdata[1:0];
    end
  end

  // sticky events: set wins over write-one-to-clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= irq_set | (irq_status & ~(wr_istat ? hwdata[1:0] : 2'h0));
    end
  end

  // start-up sequencer
  always_comb begin
    next_state = state;
    next_wait  = (wait_cnt == 32'h00000000) ? 32'h00000000 : wait_cnt - 32'h1;
    unique case (state)
      DDRC_IDLE: begin
        if (start_req) begin
          next_state = DDRC_PWRUP;
          next_wait  = PWRUP_CYC - 1;
        end
      end
      DDRC_PWRUP: begin
        if (wait_cnt == 32'h00000000) begin
          next_state = DDRC_RESET;
          next_wait  = RESET_CYC - 1;
        end
      end
      DDRC_RESET: begin
        if (wait_cnt == 32'h00000000) begin
          next_state = DDRC_CKE;
          next_wait  = FIRST_CYC - 1;
        end
      end
      DDRC_CKE: begin
        if (wait_cnt == 32'h00000000) begin
          next_state = DDRC_MRS_MR;
          next_wait  = MRS_CYC - 1;
        end
      end
      DDRC_MRS_MR: begin
        if (wait_cnt == 32'h00000000) begin
          next_state = DDRC_MRS_EM;
          next_wait  = MRS_CYC - 1;
        end
      end
      DDRC_MRS_EM: begin
        if (wait_cnt == 32'h00000000) next_state = DDRC_DONE;
      end
      DDRC_DONE: next_state = DDRC_DONE;
      default: next_state = DDRC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state      <= DDRC_IDLE;
      wait_cnt   <= 32'h00000000;
      start_seen <= 1'b0;
    end else begin
      state    <= next_state;
      wait_cnt <= next_wait;
      if (start_req) start_seen <= 1'b1;
    end
  end

  // memory-side outputs, all registered
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_type           <= DDRC_MEM_DDR2;
      mem_pwr            <= '{reset_n: 1'b0, cke: 1'b0};
      mem_mrs            <= '{valid: 1'b0, bank: 2'h0, value: 16'h0000};
      init_complete_flag <= 1'b0;
      irq                <= 1'b0;
    end else begin
      // gen3 wins if software sets both mode bits
      if (controller_control[`DDRC_CTL_GEN3_BIT]) mem_type <= DDRC_MEM_GEN3;
      else if (controller_control[`DDRC_CTL_LP_BIT]) mem_type <= DDRC_MEM_LP;
      else mem_type <= DDRC_MEM_DDR2;
      mem_pwr.reset_n <= (next_state != DDRC_IDLE) && (next_state != DDRC_PWRUP) &&
                         (next_state != DDRC_RESET);
      mem_pwr.cke     <= (next_state == DDRC_MRS_MR) || (next_state == DDRC_MRS_EM) ||
                         (next_state == DDRC_DONE);
      // one command per entry into each mode-register step
      mem_mrs.valid <= (next_state != state) &&
                       ((next_state == DDRC_MRS_MR) || (next_state == DDRC_MRS_EM));
      mem_mrs.bank  <= (next_state == DDRC_MRS_EM) ? 2'h1 : 2'h0;
      mem_mrs.value <= (next_state == DDRC_MRS_EM) ? lp_extended_mode_register[15:0]
                                                   : lp_mode_register[15:0];
      // only nrst clears the flag
      if (seq_done) init_complete_flag <= 1'b1;
      irq <= |(next_irq_status() & irq_mask);
    end
  end

  function automatic logic [1:0] next_irq_status();
    next_irq_status = irq_set | (irq_status & ~(wr_istat ? hwdata[1:0] : 2'h0));
  endfunction

  sequence s_mrs_pair;
    mem_mrs.valid && mem_mrs.bank == 2'h0 ##(MRS_CYC) mem_mrs.valid && mem_mrs.bank == 2'h1;
  endsequence

  sequence s_cke_rise;
    $rose(mem_pwr.cke);
  endsequence

  a_done_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
    init_complete_flag |=> init_complete_flag)
    else $error("done flag dropped");
  a_done_after_mrs: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(init_complete_flag) |-> $past(state) == DDRC_MRS_EM && state == DDRC_DONE)
    else $error("done set outside sequence end");
  a_start_begins: assert property (@(posedge clk_sys) disable iff (!nrst)
    start_req |=> state == DDRC_PWRUP)
    else $error("start did not begin sequence");
  a_mode_upper_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    lp_mode_register[31:13] == 19'h00000 && lp_extended_mode_register[31:8] == 24'h000000)
    else $error("unused mode bits not zero");
  a_mrs_order: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mem_mrs.valid && mem_mrs.bank == 2'h0) |-> s_mrs_pair)
    else $error("mode commands out of order");
  a_cke_after_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(mem_pwr.cke) |-> mem_pwr.reset_n && $past(mem_pwr.reset_n, 2))
    else $error("cke raised before reset release");
  a_gen3_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
    controller_control[0] |=> mem_type == DDRC_MEM_GEN3)
    else $error("gen3 mode not followed");
  a_ddr2_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
    controller_control[1:0] == 2'b00 |=> mem_type == DDRC_MEM_DDR2)
    else $error("ddr2 default not followed");
  a_flag_low_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    state != DDRC_DONE |-> !init_complete_flag)
    else $error("done flag set early");

  // bus side: zero wait and okay are fixed
  a_bus_okay: assert property (@(posedge clk_sys) disable iff (!nrst)
    hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_read_data: assert property (@(posedge clk_sys) disable iff (!nrst)
    addr_phase && !hwrite |=> hrdata == $past(rd_mux))
    else $error("read data not captured");
  a_write_lands: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_mode |=> lp_mode_register == ($past(hwdata) & `DDRC_MODE_USED_MSK))
    else $error("mode write lost");
  a_ext_lands: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_ext |=> lp_extended_mode_register == ($past(hwdata) & `DDRC_EMR_USED_MSK))
    else $error("extended mode write lost");
  a_mask_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_imask |=> irq_mask == $past(hwdata[1:0]))
    else $error("mask write lost");
  a_init_bit_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    controller_control[`DDRC_CTL_INIT_BIT] == 1'b0)
    else $error("start bit stored");
  a_idle_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == DDRC_IDLE && !start_req |=> state == DDRC_IDLE)
    else $error("sequence left idle without start");
  a_start_refused: assert property (@(posedge clk_sys) disable iff (!nrst)
    start_bad |=> irq_status[1])
    else $error("refused start not flagged");

  // interrupt and done flag
  a_done_event: assert property (@(posedge clk_sys) disable iff (!nrst)
    seq_done |=> irq_status[0] && init_complete_flag)
    else $error("done event lost");
  a_irq_on: assert property (@(posedge clk_sys) disable iff (!nrst)
    (|(irq_status & irq_mask)) && !$past(wr_imask) |-> irq)
    else $error("irq low with unmasked event");
  a_irq_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(|(irq_status & irq_mask)) && !$past(wr_imask) |-> !irq)
    else $error("irq high with no unmasked event");
  a_done_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == DDRC_DONE |=> state == DDRC_DONE)
    else $error("sequencer left done");

  // memory type selection and memory-side sequencing
  a_lp_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
    controller_control[1:0] == 2'b10 |=> mem_type == DDRC_MEM_LP)
    else $error("low-power mode not followed");
  a_gen3_wins: assert property (@(posedge clk_sys) disable iff (!nrst)
    controller_control[1:0] == 2'b11 |=> mem_type == DDRC_MEM_GEN3)
    else $error("gen3 did not win");
  a_pwrup_entry: assert property (@(posedge clk_sys) disable iff (!nrst)
    start_req |=> !mem_pwr.reset_n && !mem_pwr.cke)
    else $error("memory not held at start");
  a_reset_held: assert property (@(posedge clk_sys) disable iff (!nrst)
    state == DDRC_PWRUP || state == DDRC_RESET |-> !mem_pwr.reset_n)
    else $error("memory reset released early");
  a_cke_held: assert property (@(posedge clk_sys) disable iff (!nrst)
    state != DDRC_MRS_MR && state != DDRC_MRS_EM && state != DDRC_DONE |-> !mem_pwr.cke)
    else $error("clock enable raised early");
  a_first_cmd: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(mem_pwr.reset_n) |-> ##(FIRST_CYC) s_cke_rise)
    else $error("first command wait wrong");
  a_mrs_after_cke: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(mem_pwr.cke) |-> mem_mrs.valid && mem_mrs.bank == 2'h0)
    else $error("mode command missing at clock enable");
  a_mrs_powered: assert property (@(posedge clk_sys) disable iff (!nrst)
    mem_mrs.valid |-> mem_pwr.cke && mem_pwr.reset_n)
    else $error("mode command while memory down");
  a_mrs_single: assert property (@(posedge clk_sys) disable iff (!nrst)
    mem_mrs.valid |=> !mem_mrs.valid)
    else $error("mode command longer than one cycle");
  a_mrs_mode_val: assert property (@(posedge clk_sys) disable iff (!nrst)
    mem_mrs.valid && mem_mrs.bank == 2'h0 |-> mem_mrs.value == lp_mode_register[15:0])
    else $error("mode command value wrong");
  a_mrs_ext_val: assert property (@(posedge clk_sys) disable iff (!nrst)
    mem_mrs.valid && mem_mrs.bank == 2'h1 |-> mem_mrs.value == lp_extended_mode_register[15:0])
    else $error("extended command value wrong");
endmodule

// ---- logic/ddrc_params.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef DDRC_PARAMS_SVH
`define DDRC_PARAMS_SVH
`define DDRC_OFS_MODE      12'h000
`define DDRC_OFS_EXTMODE   12'h004
`define DDRC_OFS_CTL       12'h008
`define DDRC_OFS_LOOP      12'h00C
`define DDRC_OFS_CALADDR   12'h010
`define DDRC_OFS_STATUS    12'h014
`define DDRC_OFS_IRQ_STAT  12'h018
`define DDRC_OFS_IRQ_MASK  12'h01C
`define DDRC_MODE_USED_MSK 32'h00001FFF
`define DDRC_EMR_USED_MSK  32'h000000FF
`define DDRC_CTL_USED_MSK  32'h03003FFF
`define DDRC_LOOP_USED_MSK 32'h00000FFF
`define DDRC_CTL_GEN3_BIT  0
`define DDRC_CTL_LP_BIT    1
`define DDRC_CTL_INIT_BIT  2
`define DDRC_RST_MODE      32'h00000000
`define DDRC_RST_EXTMODE   32'h00000000
`define DDRC_RST_CTL       32'h00000000
`define DDRC_RST_LOOP      32'h00000000
`define DDRC_RST_CALADDR   32'h00000000
`define DDRC_PERIOD_NS     8
`define DDRC_PWRUP_NS      200000
`define DDRC_RESET_NS      500
`define DDRC_FIRST_CMD_NS  400
`define DDRC_MRS_NS        16
`define DDRC_PWRUP_CYC     ((`DDRC_PWRUP_NS + `DDRC_PERIOD_NS - 1) / `DDRC_PERIOD_NS)
`define DDRC_RESET_CYC     ((`DDRC_RESET_NS + `DDRC_PERIOD_NS - 1) / `DDRC_PERIOD_NS)
`define DDRC_FIRST_CMD_CYC ((`DDRC_FIRST_CMD_NS + `DDRC_PERIOD_NS - 1) / `DDRC_PERIOD_NS)
`define DDRC_MRS_CYC       ((`DDRC_MRS_NS + `DDRC_PERIOD_NS - 1) / `DDRC_PERIOD_NS)
`endif

// ---- logic/ddrc_pkg.sv ----
// types shared by the controller start-up block
package ddrc_pkg;
  typedef enum logic [2:0] {
    DDRC_IDLE   = 3'b000,
    DDRC_PWRUP  = 3'b001,
    DDRC_RESET  = 3'b010,
    DDRC_CKE    = 3'b011,
    DDRC_MRS_MR = 3'b100,
    DDRC_MRS_EM = 3'b101,
    DDRC_DONE   = 3'b110
  } ddrc_state_type;
  typedef enum logic [1:0] {
    DDRC_MEM_DDR2 = 2'b00,
    DDRC_MEM_GEN3 = 2'b01,
    DDRC_MEM_LP   = 2'b10
  } ddrc_mem_type;
  typedef struct packed {
    logic        valid;
    logic [1:0]  bank;
    logic [15:0] value;
  } ddrc_mrs_type;
  typedef struct packed {
    logic        reset_n;
    logic        cke;
  } ddrc_pwr_type;
endpackage

// ---- verif/ddrc_init_ctrl_tb_top.sv ----
// self-checking bench for the controller configuration and start-up block
`timescale 1ns/1ps
`include "ddrc_params.svh"
module ddrc_init_ctrl_tb_top;
  import ddrc_pkg::*;
  localparam int unsigned PWRUP = 10;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r;} ddrc_row_type;
  logic         clk_sys = 1'b0;
  logic         nrst, hsel, hwrite, hreadyout, hresp, irq, init_complete_flag;
  logic [31:0]  haddr, hwdata, hrdata, q;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  ddrc_mem_type mem_type;
  ddrc_pwr_type mem_pwr;
  ddrc_mrs_type mem_mrs;
  logic [15:0]  mr_seen, emr_seen;
  logic [7:0]   fault_cnt;
  int           failures = 0, cmp_count = 0, cycles = 0, n;
  ddrc_row_type rows [7] = '{
    '{`DDRC_OFS_MODE, 32'hFFFFFFFF, 32'h00001FFF},
    '{`DDRC_OFS_EXTMODE, 32'hFFFFFFFF, 32'h000000FF},
    '{`DDRC_OFS_CTL, 32'hFFFFFFFA, 32'h03003FFA},
    '{`DDRC_OFS_LOOP, 32'hFFFFFFFF, 32'h00000FFF},
    '{`DDRC_OFS_CALADDR, 32'hA5A5A5A5, 32'hA5A5A5A5},
    '{`DDRC_OFS_STATUS, 32'hFFFFFFFF, 32'h00000004},
    '{12'h020, 32'hFFFFFFFF, 32'h00000000}};
  logic [31:0]  ctl_v [3] = '{32'h00000400, 32'h00000401, 32'h00000402};
  ddrc_mem_type typ_v [3] = '{DDRC_MEM_DDR2, DDRC_MEM_GEN3, DDRC_MEM_LP};

  always #4 clk_sys = ~clk_sys;

  ddrc_init_ctrl #(.PWRUP_CYC(PWRUP)) ddrc_init_ctrl_inst (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .mem_type(mem_type), .mem_pwr(mem_pwr), .mem_mrs(mem_mrs),
    .init_complete_flag(init_complete_flag));

  ddrc_sdram_model ddrc_sdram_model_inst (
    .clk_sys(clk_sys), .mem_pwr(mem_pwr), .mem_mrs(mem_mrs),
    .mr_seen(mr_seen), .emr_seen(emr_seen), .fault_cnt(fault_cnt));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, seen, exp);
    end
  endtask

  // one single word transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // hang guard, far above the expected few hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    #1 check(init_complete_flag, 1'b0, "flag after reset");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 32'h0);
      check(q, rows[i].r, "register row");
      check(32'(hresp), 32'h0, "okay response");
    end
    $display("register table done");
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `DDRC_OFS_CTL, ctl_v[i]);
      bus(1'b0, `DDRC_OFS_CTL, 32'h0);
      check(32'(mem_type), 32'(typ_v[i]), "memory mode");
    end
    $display("mode select done");
    // burst eight, cas three, drive strength code one
    bus(1'b1, `DDRC_OFS_MODE, 32'h00000033);
    bus(1'b1, `DDRC_OFS_EXTMODE, 32'h00000020);
    bus(1'b1, `DDRC_OFS_LOOP, 32'h00000948);
    bus(1'b1, `DDRC_OFS_CALADDR, 32'h00000100);
    bus(1'b1, `DDRC_OFS_IRQ_MASK, 32'h00000003);
    bus(1'b1, `DDRC_OFS_CTL, 32'h00000406);
    n = 0;
    while (mem_pwr.reset_n !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    check(n, PWRUP + `DDRC_RESET_CYC + 1, "power-up wait");
    n = 0;
    q = 32'h0;
    while (q[0] !== 1'b1 && n < 400) begin
      bus(1'b0, `DDRC_OFS_STATUS, 32'h0);
      n++;
    end
    check(32'(q[0]), 32'h1, "done status");
    check(32'(init_complete_flag), 32'h1, "done flag");
    check(32'(mr_seen), 32'h00000033, "mode command");
    check(32'(emr_seen), 32'h00000020, "extended command");
    check(32'(fault_cnt), 32'h0, "power sequence");
    check(32'(irq), 32'h1, "done interrupt");
    $display("start-up done");
    bus(1'b1, `DDRC_OFS_CTL, 32'h00000406);
    bus(1'b0, `DDRC_OFS_IRQ_STAT, 32'h0);
    check(q, 32'h00000003, "refused start");
    bus(1'b1, `DDRC_OFS_IRQ_STAT, 32'h00000001);
    bus(1'b0, `DDRC_OFS_IRQ_STAT, 32'h0);
    check(q, 32'h00000002, "clear one bit");
    check(32'(irq), 32'h1, "irq held");
    bus(1'b1, `DDRC_OFS_IRQ_MASK, 32'h00000001);
    bus(1'b0, `DDRC_OFS_IRQ_MASK, 32'h0);
    check(32'(irq), 32'h0, "irq masked");
    bus(1'b1, `DDRC_OFS_IRQ_STAT, 32'h00000002);
    bus(1'b0, `DDRC_OFS_IRQ_STAT, 32'h0);
    check(q, 32'h00000000, "all cleared");
    check(32'(init_complete_flag), 32'h1, "flag stays");
    $display("interrupt test done");
    nrst <= 1'b0;
    #1 check(32'(init_complete_flag), 32'h0, "flag in reset");
    check(32'(mem_pwr), 32'h0, "power in reset");
    @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, `DDRC_OFS_MODE, 32'h0);
    check(q, `DDRC_RST_MODE, "mode after reset");
    check(32'(init_complete_flag), 32'h0, "flag after second reset");
    bus(1'b0, `DDRC_OFS_STATUS, 32'h0);
    check(q, 32'h00000004, "status after second reset");
    $display("second reset done");
    summarize();
  end
endmodule

// ---- verif/ddrc_sdram_model.sv ----
// behavioural memory device: power sequence watch and mode-register capture
`timescale 1ns/1ps
`include "ddrc_params.svh"
module ddrc_sdram_model
  import ddrc_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire ddrc_pwr_type mem_pwr,
  input  wire ddrc_mrs_type mem_mrs,
  output logic [15:0]       mr_seen,
  output logic [15:0]       emr_seen,
  output logic [7:0]        fault_cnt
);
  int   since_rst;
  logic cke_d;
  initial begin
    mr_seen = 16'h0000;
    emr_seen = 16'h0000;
    fault_cnt = 8'h00;
    since_rst = 0;
    cke_d = 1'b0;
  end
  always @(posedge clk_sys) begin
    since_rst <= mem_pwr.reset_n ? since_rst + 1 : 0;
    cke_d <= mem_pwr.cke;
    // memory reset is low through the reset window; the first-command wait runs with it high
    if (mem_pwr.cke && !cke_d && since_rst < `DDRC_FIRST_CMD_CYC) begin
      fault_cnt <= fault_cnt + 8'h01;
    end
    if (mem_pwr.cke && !cke_d && !mem_pwr.reset_n) fault_cnt <= fault_cnt + 8'h01;
    if (mem_mrs.valid) begin
      // a command before clock enable would be lost by a real device
      if (!mem_pwr.cke) fault_cnt <= fault_cnt + 8'h01;
      if (mem_mrs.bank == 2'h0) mr_seen <= mem_mrs.value;
      if (mem_mrs.bank == 2'h1) emr_seen <= mem_mrs.value;
    end
  end
endmodule
